// ---- shared/pll1_cfg_pkg.sv ----
// constants and types for the second pll analog configuration bank
package pll1_cfg_pkg;

    // ************************************************************
    // bus widths
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CODE_W = 5;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [15:0] LOOP_FILTER_ADDR = 16'h00b0;
    localparam logic [15:0] MODE_LOCK_ADDR   = 16'h00b1;
    localparam logic [15:0] VCO_A_CODE_ADDR  = 16'h00b2;
    localparam logic [15:0] VCO_B_CODE_ADDR  = 16'h00b3;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PUMP_LSB   = 5;
    localparam int PUMP_MSB   = 7;
    localparam int RES_LSB    = 3;
    localparam int RES_MSB    = 4;
    localparam int CAP_LSB    = 1;
    localparam int CAP_MSB    = 2;
    localparam int POLE_BIT   = 0;
    localparam int SYNTH_BIT  = 3;
    localparam int ACC_BIT    = 1;
    localparam int OVR_BIT    = 0;
    localparam int CHOICE_BIT = 5;
    localparam int CODE_MSB   = 4;

    // ************************************************************
    // field reset values
    // ************************************************************
    localparam logic [2:0] PUMP_RST   = 3'h4;
    localparam logic [1:0] RES_RST    = 2'h1;
    localparam logic [1:0] CAP_RST    = 2'h1;
    localparam logic       POLE_RST   = 1'h1;
    localparam logic       ACC_RST    = 1'h1;
    localparam logic       OVR_RST    = 1'h0;
    localparam logic       SYNTH_RST  = 1'h0;
    localparam logic       CHOICE_RST = 1'h1;
    localparam logic [4:0] VCO_A_RST  = 5'h0b;
    localparam logic [4:0] VCO_B_RST  = 5'h00;

    // ************************************************************
    // whole register reset values and implemented bit masks
    // ************************************************************
    localparam logic [7:0] LOOP_FILTER_RST  = {PUMP_RST, RES_RST, CAP_RST, POLE_RST};
    localparam logic [7:0] MODE_LOCK_RST    = {4'h0, SYNTH_RST, 1'h0, ACC_RST, OVR_RST};
    localparam logic [7:0] VCO_A_CODE_RST   = {2'h0, CHOICE_RST, VCO_A_RST};
    localparam logic [7:0] VCO_B_CODE_RST   = {3'h0, VCO_B_RST};
    localparam logic [7:0] LOOP_FILTER_MASK = 8'hff;
    localparam logic [7:0] MODE_LOCK_MASK   = 8'h0b;
    localparam logic [7:0] VCO_A_CODE_MASK  = 8'h3f;
    localparam logic [7:0] VCO_B_CODE_MASK  = 8'h1f;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;

    // ************************************************************
    // address decode result
    // ************************************************************
    typedef enum logic [2:0] {
        SEL_NONE        = 3'b000,
        SEL_LOOP_FILTER = 3'b001,
        SEL_MODE_LOCK   = 3'b010,
        SEL_VCO_A_CODE  = 3'b011,
        SEL_VCO_B_CODE  = 3'b100
    } reg_sel_type;

endpackage

// ---- logic/cfg_byte_cell.sv ----
// one byte configuration register with reset value and implemented-bit mask
`timescale 1ns/1ps
module cfg_byte_cell
    import pll1_cfg_pkg::*;
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK  = 8'hff
) (
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_b_in,
    // write side
    input  wire logic             wr_en_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    // stored value
    output logic      [DATA_W-1:0] value_out
);

    logic [DATA_W-1:0] value_q;

    // ************************************************************
    // storage, reserved bits never stored
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            value_q <= RESET_VALUE & WRITE_MASK;
        end else if (wr_en_in) begin
            value_q <= wdata_in & WRITE_MASK;
        end
    end

    assign value_out = value_q;

    cell_mask_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
        (value_q & ~WRITE_MASK) == 8'h00)
        else $error("reserved bit stored in cell");

endmodule

// ---- logic/lock_code_select.sv ----
// picks the lock code and vco handed to the analog core
`timescale 1ns/1ps
module lock_code_select
    import pll1_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_b_in,
    // selection controls
    input  wire logic              manual_lock_override_in,
    input  wire logic              manual_vco_choice_in,
    input  wire logic [CODE_W-1:0] vco_a_lock_code_in,
    input  wire logic [CODE_W-1:0] vco_b_lock_code_in,
    input  wire logic [CODE_W-1:0] auto_lock_code_in,
    input  wire logic              auto_vco_a_in,
    // applied selection
    output logic      [CODE_W-1:0] applied_lock_code_out,
    output logic                   applied_vco_a_out
);

    logic [CODE_W-1:0] code_q;
    logic              vco_a_q;

    // ************************************************************
    // manual or automatic lock source
    // ************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            code_q  <= VCO_A_RST;
            vco_a_q <= CHOICE_RST;
        end else if (manual_lock_override_in) begin
            vco_a_q <= manual_vco_choice_in;
            code_q  <= manual_vco_choice_in ? vco_a_lock_code_in : vco_b_lock_code_in;
        end else begin
            vco_a_q <= auto_vco_a_in;
            code_q  <= auto_lock_code_in;
        end
    end

    assign applied_lock_code_out = code_q;
    assign applied_vco_a_out     = vco_a_q;

endmodule

// ---- logic/pll1_analog_config_regs.sv ----
// register bank holding the analog configuration of the second pll
`timescale 1ns/1ps
module pll1_analog_config_regs
    import pll1_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_b_in,
    // register access port
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic              reg_wr_en_in,
    input  wire logic              reg_rd_en_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    output logic      [DATA_W-1:0] reg_rdata_out,
    output logic                   reg_rdata_valid_out,
    output logic                   reg_hit_out,
    // loop filter and pump controls
    output logic      [2:0]        pump_current_sel_out,
    output logic      [1:0]        filter_series_res_sel_out,
    output logic      [1:0]        filter_parallel_cap_sel_out,
    output logic                   second_pole_sel_out,
    // mode and lock controls
    output logic                   lock_count_accuracy_out,
    output logic                   manual_lock_override_out,
    output logic                   synth_only_mode_out,
    output logic                   manual_vco_choice_out,
    output logic      [CODE_W-1:0] vco_a_lock_code_out,
    output logic      [CODE_W-1:0] vco_b_lock_code_out,
    // lock state from the digital pll
    input  wire logic [CODE_W-1:0] auto_lock_code_in,
    input  wire logic              auto_vco_a_in,
    // lock selection applied to the analog core
    output logic      [CODE_W-1:0] applied_lock_code_out,
    output logic                   applied_vco_a_out
);

    reg_sel_type       sel;
    logic [DATA_W-1:0] loop_filter_value;
    logic [DATA_W-1:0] mode_lock_value;
    logic [DATA_W-1:0] vco_a_value;
    logic [DATA_W-1:0] vco_b_value;
    logic [DATA_W-1:0] read_mux;
    logic [DATA_W-1:0] rdata_q;
    logic              rdata_valid_q;
    logic              wr_loop_filter;
    logic              wr_mode_lock;
    logic              wr_vco_a;
    logic              wr_vco_b;

    // ************************************************************
    // address decode
    // ************************************************************
    // consecutive byte map
    always_comb begin
        case (reg_addr_in)
            LOOP_FILTER_ADDR: sel = SEL_LOOP_FILTER;
            MODE_LOCK_ADDR:   sel = SEL_MODE_LOCK;
            VCO_A_CODE_ADDR:  sel = SEL_VCO_A_CODE;
            VCO_B_CODE_ADDR:  sel = SEL_VCO_B_CODE;
            default:          sel = SEL_NONE;
        endcase
    end

    assign reg_hit_out    = (sel != SEL_NONE);
    assign wr_loop_filter = reg_wr_en_in && (sel == SEL_LOOP_FILTER);
    assign wr_mode_lock   = reg_wr_en_in && (sel == SEL_MODE_LOCK);
    assign wr_vco_a       = reg_wr_en_in && (sel == SEL_VCO_A_CODE);
    assign wr_vco_b       = reg_wr_en_in && (sel == SEL_VCO_B_CODE);

    // ************************************************************
    // register storage
    // ************************************************************
    // pump, resistor, capacitor, pole byte
    cfg_byte_cell #(
        .RESET_VALUE (LOOP_FILTER_RST),
        .WRITE_MASK  (LOOP_FILTER_MASK)
    ) loop_filter_cell (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (wr_loop_filter),
        .wdata_in    (reg_wdata_in),
        .value_out   (loop_filter_value)
    );

    cfg_byte_cell #(
        .RESET_VALUE (MODE_LOCK_RST),
        .WRITE_MASK  (MODE_LOCK_MASK)
    ) mode_lock_cell (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (wr_mode_lock),
        .wdata_in    (reg_wdata_in),
        .value_out   (mode_lock_value)
    );

    cfg_byte_cell #(
        .RESET_VALUE (VCO_A_CODE_RST),
        .WRITE_MASK  (VCO_A_CODE_MASK)
    ) vco_a_cell (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (wr_vco_a),
        .wdata_in    (reg_wdata_in),
        .value_out   (vco_a_value)
    );

    cfg_byte_cell #(
        .RESET_VALUE (VCO_B_CODE_RST),
        .WRITE_MASK  (VCO_B_CODE_MASK)
    ) vco_b_cell (
        .core_clk_in (core_clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (wr_vco_b),
        .wdata_in    (reg_wdata_in),
        .value_out   (vco_b_value)
    );

    // ************************************************************
    // field outputs to the analog core
    // ************************************************************
    // pump field slice
    assign pump_current_sel_out        = loop_filter_value[PUMP_MSB:PUMP_LSB];
    assign filter_series_res_sel_out   = loop_filter_value[RES_MSB:RES_LSB];
    assign filter_parallel_cap_sel_out = loop_filter_value[CAP_MSB:CAP_LSB];
    assign second_pole_sel_out         = loop_filter_value[POLE_BIT];
    assign lock_count_accuracy_out     = mode_lock_value[ACC_BIT];
    assign manual_lock_override_out    = mode_lock_value[OVR_BIT];
    assign synth_only_mode_out         = mode_lock_value[SYNTH_BIT];
    assign manual_vco_choice_out       = vco_a_value[CHOICE_BIT];
    assign vco_a_lock_code_out         = vco_a_value[CODE_MSB:0];
    assign vco_b_lock_code_out         = vco_b_value[CODE_MSB:0];

    // ************************************************************
    // lock source selection
    // ************************************************************
    // override picks manual codes
    lock_code_select lock_select (
        .core_clk_in             (core_clk_in),
        .rst_b_in                (rst_b_in),
        .manual_lock_override_in (manual_lock_override_out),
        .manual_vco_choice_in    (manual_vco_choice_out),
        .vco_a_lock_code_in      (vco_a_lock_code_out),
        .vco_b_lock_code_in      (vco_b_lock_code_out),
        .auto_lock_code_in       (auto_lock_code_in),
        .auto_vco_a_in           (auto_vco_a_in),
        .applied_lock_code_out   (applied_lock_code_out),
        .applied_vco_a_out       (applied_vco_a_out)
    );

    // ************************************************************
    // read path
    // ************************************************************
    // read returns stored value
    always_comb begin
        case (sel)
            SEL_LOOP_FILTER: read_mux = loop_filter_value;
            SEL_MODE_LOCK:   read_mux = mode_lock_value;
            SEL_VCO_A_CODE:  read_mux = vco_a_value;
            SEL_VCO_B_CODE:  read_mux = vco_b_value;
            default:         read_mux = READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rdata_q <= READ_UNMAPPED;
        end else if (reg_rd_en_in) begin
            rdata_q <= read_mux;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            rdata_valid_q <= 1'h0;
        end else begin
            rdata_valid_q <= reg_rd_en_in;
        end
    end

    assign reg_rdata_out       = rdata_q;
    assign reg_rdata_valid_out = rdata_valid_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking chk_clk @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    pump_reset_a: assert property ($past(!rst_b_in) |-> pump_current_sel_out == PUMP_RST)
        else $error("pump current default wrong");

    filter_reset_a: assert property ($past(!rst_b_in) |->
        filter_series_res_sel_out == RES_RST && filter_parallel_cap_sel_out == CAP_RST)
        else $error("filter defaults wrong");

    pole_write_a: assert property (wr_loop_filter |=> second_pole_sel_out == $past(reg_wdata_in[POLE_BIT]))
        else $error("second pole not written");

    accuracy_reset_a: assert property ($past(!rst_b_in) |-> lock_count_accuracy_out == ACC_RST)
        else $error("accuracy default wrong");

    manual_apply_a: assert property (
        manual_lock_override_out && manual_vco_choice_out |=> applied_lock_code_out == $past(vco_a_lock_code_out))
        else $error("manual first vco code not applied");

    // second vco chosen when choice low
    choice_apply_a: assert property (
        manual_lock_override_out && !manual_vco_choice_out |=>
        applied_lock_code_out == $past(vco_b_lock_code_out) && !applied_vco_a_out)
        else $error("manual second vco not applied");

    code_reset_a: assert property ($past(!rst_b_in) |->
        vco_a_lock_code_out == VCO_A_RST && vco_b_lock_code_out == VCO_B_RST && manual_vco_choice_out)
        else $error("lock code defaults wrong");

    synth_hold_a: assert property (!wr_mode_lock ##1 !wr_mode_lock |-> $stable(synth_only_mode_out))
        else $error("synth mode changed without write");

    reserved_zero_a: assert property (reg_rd_en_in && sel == SEL_MODE_LOCK |=>
        (reg_rdata_out & ~MODE_LOCK_MASK) == 8'h00)
        else $error("reserved bits readback nonzero");

    unmapped_read_a: assert property (reg_rd_en_in && sel == SEL_NONE |=> reg_rdata_out == READ_UNMAPPED)
        else $error("unmapped read nonzero");

    write_read_a: assert property (wr_vco_b ##1 (reg_rd_en_in && sel == SEL_VCO_B_CODE && !reg_wr_en_in) |=>
        reg_rdata_out == ($past(reg_wdata_in, 2) & VCO_B_CODE_MASK) && reg_rdata_valid_out)
        else $error("readback differs from write");

    // loop filter write leaves the mode lock and first vco registers unchanged
    no_side_a: assert property (wr_loop_filter |=> $stable(mode_lock_value) && $stable(vco_a_value))
        else $error("write touched another register");

    hit_decode_a: assert property (reg_hit_out == (reg_addr_in >= LOOP_FILTER_ADDR && reg_addr_in <= VCO_B_CODE_ADDR))
        else $error("address hit wrong");

    read_valid_a: assert property (reg_rd_en_in |=> reg_rdata_valid_out)
        else $error("read valid missing");

    valid_drop_a: assert property (!reg_rd_en_in |=> !reg_rdata_valid_out)
        else $error("read valid without read");

    auto_apply_a: assert property (!manual_lock_override_out |=>
        applied_lock_code_out == $past(auto_lock_code_in) && applied_vco_a_out == $past(auto_vco_a_in))
        else $error("automatic lock source not applied");

    synth_write_a: assert property (wr_mode_lock |=> synth_only_mode_out == $past(reg_wdata_in[SYNTH_BIT]))
        else $error("synth mode not written");

    filter_write_a: assert property (wr_loop_filter |=>
        filter_parallel_cap_sel_out == $past(reg_wdata_in[CAP_MSB:CAP_LSB]) &&
        filter_series_res_sel_out == $past(reg_wdata_in[RES_MSB:RES_LSB]))
        else $error("filter fields not written");

    code_write_a: assert property (wr_vco_b |=> vco_b_lock_code_out == $past(reg_wdata_in[CODE_MSB:0]))
        else $error("second vco code not written");

    synth_on_c: cover property (wr_mode_lock ##1 synth_only_mode_out);
    manual_on_c: cover property (manual_lock_override_out ##1 manual_vco_choice_out ##2 !manual_vco_choice_out);
    readback_c: cover property (wr_loop_filter ##1 reg_rd_en_in && sel == SEL_LOOP_FILTER);
    unmapped_c: cover property (reg_rd_en_in && sel == SEL_NONE);

endmodule

// ---- tb/tb_pll1_analog_config_regs.sv ----
// self-checking bench for the second pll analog configuration bank
`timescale 1ns/1ps
module tb_pll1_analog_config_regs
    import pll1_cfg_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic              core_clk_in;
    logic              rst_b_in;
    logic [ADDR_W-1:0] reg_addr_in;
    logic              reg_wr_en_in;
    logic              reg_rd_en_in;
    logic [DATA_W-1:0] reg_wdata_in;
    logic [DATA_W-1:0] reg_rdata_out;
    logic              reg_rdata_valid_out;
    logic              reg_hit_out;
    logic [2:0]        pump_current_sel_out;
    logic [1:0]        filter_series_res_sel_out;
    logic [1:0]        filter_parallel_cap_sel_out;
    logic              second_pole_sel_out;
    logic              lock_count_accuracy_out;
    logic              manual_lock_override_out;
    logic              synth_only_mode_out;
    logic              manual_vco_choice_out;
    logic [CODE_W-1:0] vco_a_lock_code_out;
    logic [CODE_W-1:0] vco_b_lock_code_out;
    logic [CODE_W-1:0] auto_lock_code_in;
    logic              auto_vco_a_in;
    logic [CODE_W-1:0] applied_lock_code_out;
    logic              applied_vco_a_out;
    int                error_cnt;
    int                n_checks;

    pll1_analog_config_regs u_dut (
        .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wr_en_in(reg_wr_en_in), .reg_rd_en_in(reg_rd_en_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_rdata_valid_out(reg_rdata_valid_out), .reg_hit_out(reg_hit_out),
        .pump_current_sel_out(pump_current_sel_out), .filter_series_res_sel_out(filter_series_res_sel_out),
        .filter_parallel_cap_sel_out(filter_parallel_cap_sel_out), .second_pole_sel_out(second_pole_sel_out),
        .lock_count_accuracy_out(lock_count_accuracy_out), .manual_lock_override_out(manual_lock_override_out),
        .synth_only_mode_out(synth_only_mode_out), .manual_vco_choice_out(manual_vco_choice_out),
        .vco_a_lock_code_out(vco_a_lock_code_out), .vco_b_lock_code_out(vco_b_lock_code_out),
        .auto_lock_code_in(auto_lock_code_in), .auto_vco_a_in(auto_vco_a_in),
        .applied_lock_code_out(applied_lock_code_out), .applied_vco_a_out(applied_vco_a_out)
    );

    // ************************************************************
    // clock and helpers
    // ************************************************************
    initial begin
        core_clk_in = 1'b0;
        forever #20 core_clk_in = ~core_clk_in;
    end

    task automatic tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp_v, input string what);
        n_checks++;
        if (got !== exp_v) begin
            error_cnt++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp_v);
        end
    endtask

    task automatic chk_fields(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        chk({pump_current_sel_out, filter_series_res_sel_out, filter_parallel_cap_sel_out, second_pole_sel_out},
            b0, "loop filter fields");
        chk({4'h0, synth_only_mode_out, 1'h0, lock_count_accuracy_out, manual_lock_override_out},
            b1 & MODE_LOCK_MASK, "mode fields");
        chk({2'h0, manual_vco_choice_out, vco_a_lock_code_out}, b2 & VCO_A_CODE_MASK, "vco a fields");
        chk({3'h0, vco_b_lock_code_out}, b3 & VCO_B_CODE_MASK, "vco b fields");
    endtask

    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge core_clk_in);
        reg_addr_in  <= addr;
        reg_wdata_in <= data;
        reg_wr_en_in <= 1'h1;
        @(posedge core_clk_in);
        reg_wr_en_in <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic [15:0] addr, input logic [7:0] exp_v, input logic [7:0] mask);
        @(posedge core_clk_in);
        reg_addr_in  <= addr;
        reg_rd_en_in <= 1'h1;
        #1;
        chk({7'h0, reg_hit_out}, {7'h0, addr >= LOOP_FILTER_ADDR && addr <= VCO_B_CODE_ADDR}, "hit");
        @(posedge core_clk_in);
        reg_rd_en_in <= 1'h0;
        #1;
        chk({7'h0, reg_rdata_valid_out}, 8'h01, "read valid");
        chk(reg_rdata_out & mask, exp_v & mask, "read data");
    endtask

    task automatic rd_all(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
        rd(LOOP_FILTER_ADDR, b0, LOOP_FILTER_MASK);
        rd(MODE_LOCK_ADDR, b1, MODE_LOCK_MASK);
        rd(VCO_A_CODE_ADDR, b2, VCO_A_CODE_MASK);
        rd(VCO_B_CODE_ADDR, b3, VCO_B_CODE_MASK);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset_values;
        chk_fields(8'h8b, 8'h02, 8'h2b, 8'h00);
        rd_all(8'h8b, 8'h02, 8'h2b, 8'h00);
    endtask

    task automatic t_patterns;
        logic [7:0] pat [4];
        pat = '{8'h00, 8'h55, 8'haa, 8'hff};
        for (int i = 0; i < 4; i++) begin
            wr(LOOP_FILTER_ADDR, pat[i]);
            wr(MODE_LOCK_ADDR, pat[i] & MODE_LOCK_MASK);
            wr(VCO_A_CODE_ADDR, pat[i] & VCO_A_CODE_MASK);
            wr(VCO_B_CODE_ADDR, pat[i] & VCO_B_CODE_MASK);
            chk_fields(pat[i], pat[i], pat[i], pat[i]);
            rd_all(pat[i], pat[i], pat[i], pat[i]);
        end
        for (int c = 0; c < 8; c++) begin
            wr(LOOP_FILTER_ADDR, {c[2:0], 5'h0a});
            chk({5'h0, pump_current_sel_out}, {5'h0, c[2:0]}, "pump code");
            chk({6'h0, filter_parallel_cap_sel_out}, 8'h01, "cap code");
        end
    endtask

    task automatic t_unmapped;
        wr(16'h00b0, 8'h8b);
        wr(16'h00b4, 8'hff);
        wr(16'h00af, 8'h00);
        chk_fields(8'h8b, 8'hff, 8'hff, 8'hff);
        rd(16'h00b4, READ_UNMAPPED, 8'hff);
        rd(16'h01b0, READ_UNMAPPED, 8'hff);
    endtask

    task automatic t_same_cycle;
        wr(LOOP_FILTER_ADDR, 8'hc3);
        @(posedge core_clk_in);
        reg_addr_in  <= LOOP_FILTER_ADDR;
        reg_wdata_in <= 8'h3c;
        reg_wr_en_in <= 1'h1;
        reg_rd_en_in <= 1'h1;
        @(posedge core_clk_in);
        reg_addr_in  <= VCO_B_CODE_ADDR;
        reg_wdata_in <= 8'h11;
        reg_rd_en_in <= 1'h0;
        #1;
        chk(reg_rdata_out, 8'hc3, "read before write");
        @(posedge core_clk_in);
        reg_wr_en_in <= 1'h0;
        reg_rd_en_in <= 1'h1;
        #1;
        chk({7'h0, reg_rdata_valid_out}, 8'h00, "valid one cycle");
        chk_fields(8'h3c, 8'h0b, 8'h3f, 8'h11);
        @(posedge core_clk_in);
        reg_rd_en_in <= 1'h0;
        #1;
        chk(reg_rdata_out, 8'h11, "read right after write");
    endtask

    task automatic t_lock_select;
        wr(MODE_LOCK_ADDR, 8'h00);
        @(posedge core_clk_in);
        auto_lock_code_in <= 5'h13;
        auto_vco_a_in     <= 1'h0;
        @(posedge core_clk_in);
        #1;
        chk({2'h0, applied_vco_a_out, applied_lock_code_out}, 8'h13, "auto follow");
        wr(VCO_A_CODE_ADDR, 8'h3a);
        wr(VCO_B_CODE_ADDR, 8'h05);
        wr(MODE_LOCK_ADDR, 8'h01);
        @(posedge core_clk_in);
        auto_lock_code_in <= 5'h07;
        @(posedge core_clk_in);
        #1;
        chk({2'h0, applied_vco_a_out, applied_lock_code_out}, 8'h3a, "manual first vco");
        wr(VCO_A_CODE_ADDR, 8'h1a);
        @(posedge core_clk_in);
        #1;
        chk({2'h0, applied_vco_a_out, applied_lock_code_out}, 8'h05, "manual second vco");
        wr(MODE_LOCK_ADDR, 8'h08);
        chk({7'h0, synth_only_mode_out}, 8'h01, "synth mode on");
    endtask

    task automatic t_mid_reset;
        wr(LOOP_FILTER_ADDR, 8'h00);
        @(posedge core_clk_in);
        rst_b_in <= 1'h0;
        repeat (2) @(posedge core_clk_in);
        rst_b_in <= 1'h1;
        #1;
        chk_fields(8'h8b, 8'h02, 8'h2b, 8'h00);
        rd_all(8'h8b, 8'h02, 8'h2b, 8'h00);
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        error_cnt         = 0;
        n_checks          = 0;
        rst_b_in          = 1'h0;
        reg_addr_in       = 16'h0000;
        reg_wr_en_in      = 1'h0;
        reg_rd_en_in      = 1'h0;
        reg_wdata_in      = 8'h00;
        auto_lock_code_in = 5'h00;
        auto_vco_a_in     = 1'h1;
        repeat (20) @(posedge core_clk_in);
        rst_b_in <= 1'h1;
        #1;
        t_reset_values();
        t_patterns();
        t_unmapped();
        t_same_cycle();
        t_lock_select();
        t_mid_reset();
        tally_and_finish();
    end

    initial begin
        repeat (4000) @(posedge core_clk_in);
        error_cnt++;
        tally_and_finish();
    end
endmodule
